// [rtl/hdca_pkg.sv]
// Purpose: Constants for the HDLC channel assignment block
// Assumes: 8-bit register port, 24 DS0 slots per T1 frame
// Notes:   Offsets are byte addresses of the control port
//
// Functional notes
// R1: Host writes packet bytes at 0x08, MSB first
// R2: Bit 7 selects DS0 service over data link
// R3: Host writes zero to control bit 6
// R4: Single mode uses 5-bit channel number
// R5: Suppress bits 7..0 drop DS0 bits 8..1
// R6: Bit 5 selects channel number or block-select
package hdca_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] HDCA_TX_FIFO_OFF  = 8'h08; // Transmit packet byte port
    localparam logic [7:0] HDCA_RX_CTRL_OFF  = 8'h90; // Receive slot control
    localparam logic [7:0] HDCA_RX_SUPP_OFF  = 8'h91; // Receive bit suppress
    localparam logic [7:0] HDCA_TX_CTRL_OFF  = 8'h92; // Transmit slot control

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         HDCA_ENABLE_BIT   = 7;     // Slot service enable
    localparam int         HDCA_UNUSED_BIT   = 6;     // Unassigned position
    localparam int         HDCA_MODE_BIT     = 5;     // Selection mode
    localparam int         HDCA_CHAN_MSB     = 4;     // Channel number top
    localparam logic [7:0] HDCA_CTRL_RST     = 8'h00; // Control reset value
    localparam logic [7:0] HDCA_SUPP_RST     = 8'h00; // Suppress reset value
    localparam logic [7:0] HDCA_UNMAPPED_RD  = 8'h00; // Answer for unmapped reads
    localparam logic [7:0] HDCA_CTRL_WMASK   = 8'hbf; // Bit 6 held at zero
    localparam logic [4:0] HDCA_LAST_SLOT    = 5'h17; // Slot 24 counted from zero
    localparam logic [2:0] HDCA_LAST_BIT     = 3'h7;  // DS0 bit 1 is last in slot
endpackage

// [rtl/hdca_slot_gate.sv]
// Purpose: Decides per DS0 bit whether HDLC data uses it
// Assumes: slot/bit position given by the framer each bit time
// Notes:   Pure combinational gate, one per direction
`timescale 1ns/1ps
module hdca_slot_gate
    import hdca_pkg::*;
(
    // Control register contents
    input  wire logic [7:0] slotCtrl,
    input  wire logic [7:0] bitSuppress,
    // Framer position
    input  wire logic [4:0] slotNum,
    input  wire logic [2:0] bitNum,
    input  wire logic       blockSelect,
    // Decision
    output logic            useFdl,
    output logic            useBit
);
    logic slotHit; // Slot selected by mode

    // --------------------------------------------------------
    // Slot selection
    // --------------------------------------------------------
    always_comb begin
        if (slotCtrl[HDCA_MODE_BIT]) begin
            slotHit = blockSelect; // [R6]
        end else begin
            slotHit = (slotNum == slotCtrl[HDCA_CHAN_MSB:0]); // [R4]
        end
        // Bit 0 of the suppress mask is the last DS0 bit sent
        useBit = slotCtrl[HDCA_ENABLE_BIT] && slotHit
               && !bitSuppress[HDCA_LAST_BIT - bitNum]; // [R5]
        useFdl = !slotCtrl[HDCA_ENABLE_BIT]; // [R2]
    end
endmodule

// [rtl/hdca_tx_byte_port.sv]
// Purpose: Holds the last packet byte written by the host
// Assumes: downstream HDLC core takes each byte on its one-cycle valid pulse
// Notes:   One byte of staging, no FIFO depth here
`timescale 1ns/1ps
module hdca_tx_byte_port
    import hdca_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // Host side
    input  wire logic       byteWrite,
    input  wire logic [7:0] byteIn,
    // HDLC core side
    output logic [7:0]      txByte,
    output logic            txByteValid
);
    typedef struct packed {
        logic [7:0] data;
        logic       valid;
    } hdca_byte_t;

    hdca_byte_t st_r;   // Registered state
    hdca_byte_t st_nxt; // Next state

    // --------------------------------------------------------
    // Capture byte, pulse valid for one cycle
    // --------------------------------------------------------
    always_comb begin
        st_nxt       = st_r;
        st_nxt.valid = byteWrite;
        if (byteWrite) begin
            st_nxt.data = byteIn; // Bit 7 stays packet MSB [R1]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign txByte      = st_r.data;
    assign txByteValid = st_r.valid;
endmodule

// [rtl/hdca_top.sv]
// Purpose: Register port and channel routing for both HDLC directions
// Assumes: host strobes are one cycle and never overlap
// Notes:   Read data stands only in the cycle after the read strobe
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module hdca_top
    import hdca_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // Host register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic [7:0]      regRdData,
    // Receive framer position
    input  wire logic [4:0] rxSlotNum,
    input  wire logic [2:0] rxBitNum,
    input  wire logic       rxChannelBlockSelect,
    // Transmit framer position
    input  wire logic [4:0] txSlotNum,
    input  wire logic [2:0] txBitNum,
    input  wire logic       txChannelBlockSelect,
    // Routing decisions
    output logic            rxUseFacilityDataLink,
    output logic            rxHdlcBitEnable,
    output logic            txUseFacilityDataLink,
    output logic            txHdlcBitEnable,
    // Transmit byte toward the HDLC core
    output logic [7:0]      txHdlcByte,
    output logic            txHdlcByteValid
);
    // --------------------------------------------------------
    // State
    // --------------------------------------------------------
    typedef struct packed {
        logic [7:0] rxCtrl;   // rx_hdlc_slot_control
        logic [7:0] rxSupp;   // rx_hdlc_bit_suppress
        logic [7:0] txCtrl;   // tx_hdlc_slot_control
        logic [7:0] rdData;   // Read answer
    } hdca_regs_t;

    hdca_regs_t st_r;   // Registered state
    hdca_regs_t st_nxt; // Next state

    logic       rxFdl;  // Receive serves data link
    logic       rxBit;  // Receive bit used
    logic       txFdl;  // Transmit serves data link
    logic       txBit;  // Transmit bit used

    // Read decode used by the read path
    function automatic logic [7:0] readMux(input logic [7:0] a, input hdca_regs_t s);
        case (a)
            HDCA_RX_CTRL_OFF: readMux = s.rxCtrl;
            HDCA_RX_SUPP_OFF: readMux = s.rxSupp;
            HDCA_TX_CTRL_OFF: readMux = s.txCtrl;
            default:          readMux = HDCA_UNMAPPED_RD; // Byte port is write only
        endcase
    endfunction

    // --------------------------------------------------------
    // Register writes and read answer
    // --------------------------------------------------------
    always_comb begin
        st_nxt        = st_r;
        st_nxt.rdData = HDCA_UNMAPPED_RD; // Data only after a read
        if (regWrite) begin
            case (regAddr)
                // Bit 6 forced low so a careless host cannot set it [R3]
                HDCA_RX_CTRL_OFF: st_nxt.rxCtrl = regWrData & HDCA_CTRL_WMASK; // [R2]
                HDCA_RX_SUPP_OFF: st_nxt.rxSupp = regWrData; // [R5]
                HDCA_TX_CTRL_OFF: st_nxt.txCtrl = regWrData & HDCA_CTRL_WMASK; // [R2]
                default:          st_nxt.rxSupp = st_r.rxSupp; // No register here
            endcase
        end
        if (regRead) begin
            st_nxt.rdData = readMux(regAddr, st_r);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= '{HDCA_CTRL_RST, HDCA_SUPP_RST, HDCA_CTRL_RST, HDCA_UNMAPPED_RD};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData = st_r.rdData;

    // --------------------------------------------------------
    // Per-direction slot gates
    // --------------------------------------------------------
    hdca_slot_gate u_rxGate (
        .slotCtrl    (st_r.rxCtrl),
        .bitSuppress (st_r.rxSupp),
        .slotNum     (rxSlotNum),
        .bitNum      (rxBitNum),
        .blockSelect (rxChannelBlockSelect),
        .useFdl      (rxFdl),
        .useBit      (rxBit)
    );

    // Transmit has no suppress register in this block
    hdca_slot_gate u_txGate (
        .slotCtrl    (st_r.txCtrl),
        .bitSuppress (HDCA_SUPP_RST),
        .slotNum     (txSlotNum),
        .bitNum      (txBitNum),
        .blockSelect (txChannelBlockSelect),
        .useFdl      (txFdl),
        .useBit      (txBit)
    );

    assign rxUseFacilityDataLink = rxFdl;
    assign rxHdlcBitEnable       = rxBit;
    assign txUseFacilityDataLink = txFdl;
    assign txHdlcBitEnable       = txBit;

    // --------------------------------------------------------
    // Transmit packet byte port
    // --------------------------------------------------------
    hdca_tx_byte_port u_txPort (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .byteWrite   (regWrite && (regAddr == HDCA_TX_FIFO_OFF)), // [R1]
        .byteIn      (regWrData),
        .txByte      (txHdlcByte),
        .txByteValid (txHdlcByteValid)
    );

    // --------------------------------------------------------
    // Assertions
    // --------------------------------------------------------
    // One clock for every check; reset masks them while state clears,
    // but a sampled-value function can still look back into the last cycle of reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Packet byte port: one pulse per write, byte kept until the next
    byte_port_pass_a: assert property ( // [R1]
        regWrite && regAddr == HDCA_TX_FIFO_OFF
        |=> txHdlcByteValid && txHdlcByte == $past(regWrData))
        else $error("packet byte not passed");
    byte_valid_cause_a: assert property ( // [R1]
        txHdlcByteValid |-> $past(regWrite) && $past(regAddr) == HDCA_TX_FIFO_OFF)
        else $error("spurious byte valid");
    // A stale byte must not move, the core may still be reading it
    byte_hold_a: assert property ( // [R1]
        !(regWrite && regAddr == HDCA_TX_FIFO_OFF) |=> $stable(txHdlcByte))
        else $error("packet byte moved without write");

    // Data link versus time slot service, both directions
    fdl_route_a: assert property ( // [R2]
        rxUseFacilityDataLink == !st_r.rxCtrl[HDCA_ENABLE_BIT]
        && !(rxUseFacilityDataLink && rxHdlcBitEnable))
        else $error("receive route wrong");
    tx_fdl_route_a: assert property ( // [R2]
        txUseFacilityDataLink == !st_r.txCtrl[HDCA_ENABLE_BIT]
        && !(txUseFacilityDataLink && txHdlcBitEnable))
        else $error("transmit route wrong");

    // Control writes land in the next cycle with bit 6 cleared
    ctrl_write_a: assert property ( // [R2]
        regWrite && regAddr == HDCA_RX_CTRL_OFF
        |=> st_r.rxCtrl == ($past(regWrData) & HDCA_CTRL_WMASK))
        else $error("receive control not stored");
    tx_ctrl_write_a: assert property ( // [R2]
        regWrite && regAddr == HDCA_TX_CTRL_OFF
        |=> st_r.txCtrl == ($past(regWrData) & HDCA_CTRL_WMASK))
        else $error("transmit control not stored");
    unused_zero_a: assert property ( // [R3]
        !st_r.rxCtrl[HDCA_UNUSED_BIT] && !st_r.txCtrl[HDCA_UNUSED_BIT])
        else $error("unassigned bit set");

    // Single channel mode: only the numbered slot may carry data
    single_slot_a: assert property ( // [R4]
        rxHdlcBitEnable && !st_r.rxCtrl[HDCA_MODE_BIT]
        |-> rxSlotNum == st_r.rxCtrl[HDCA_CHAN_MSB:0])
        else $error("wrong single slot");
    tx_single_slot_a: assert property ( // [R4]
        txHdlcBitEnable && !st_r.txCtrl[HDCA_MODE_BIT]
        |-> txSlotNum == st_r.txCtrl[HDCA_CHAN_MSB:0])
        else $error("wrong transmit slot");

    // Receive suppress mask: stored as written, applied per bit
    suppress_write_a: assert property ( // [R5]
        regWrite && regAddr == HDCA_RX_SUPP_OFF
        |=> st_r.rxSupp == $past(regWrData))
        else $error("suppress mask not stored");
    suppress_bit_a: assert property ( // [R5]
        st_r.rxSupp[HDCA_LAST_BIT - rxBitNum] |-> !rxHdlcBitEnable)
        else $error("suppressed bit used");
    read_back_a: assert property ( // [R5]
        regWrite && regAddr == HDCA_RX_SUPP_OFF ##1 regRead && regAddr == HDCA_RX_SUPP_OFF
        |=> regRdData == $past(regWrData, 2))
        else $error("read back mismatch");

    // Block select mode: the framer's marker decides per slot
    block_mode_a: assert property ( // [R6]
        st_r.txCtrl[HDCA_ENABLE_BIT] && st_r.txCtrl[HDCA_MODE_BIT]
        |-> txHdlcBitEnable == txChannelBlockSelect)
        else $error("block select ignored");
    rx_block_mode_a: assert property ( // [R6]
        st_r.rxCtrl[HDCA_ENABLE_BIT] && st_r.rxCtrl[HDCA_MODE_BIT]
        |-> rxHdlcBitEnable == (rxChannelBlockSelect
        && !st_r.rxSupp[HDCA_LAST_BIT - rxBitNum]))
        else $error("receive block select ignored");

    // Main scenarios worth seeing at least once
    single_cov_c: cover property (rxHdlcBitEnable && !st_r.rxCtrl[HDCA_MODE_BIT]);
    block_cov_c: cover property (txHdlcBitEnable && st_r.txCtrl[HDCA_MODE_BIT]);
    byte_cov_c: cover property (txHdlcByteValid ##1 txHdlcByteValid);
    supp_cov_c: cover property (st_r.rxSupp != HDCA_SUPP_RST && rxHdlcBitEnable);
    rx_block_cov_c: cover property (rxHdlcBitEnable && st_r.rxCtrl[HDCA_MODE_BIT]);
endmodule

// [testbench/hdca_host_model.sv]
// Purpose: Host processor model on the register port
// Assumes: one strobe per call, two in wr_rd and wr_pair, read data one cycle later
// Notes:   Write data is inverted after use so stale data never matches
`timescale 1ns/1ps
module hdca_host_model
    import hdca_pkg::*;
(
    // Clock
    input  wire logic       sys_clk,
    // Register port
    output logic [7:0]      regAddr,
    output logic [7:0]      regWrData,
    output logic            regWrite,
    output logic            regRead,
    input  wire logic [7:0] regRdData
);
    // -----------------------------------------------
    // Idle bus at time zero
    // -----------------------------------------------
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
    end

    // One-cycle write, bit 6 of slot controls kept clear
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        if (a == HDCA_RX_CTRL_OFF || a == HDCA_TX_CTRL_OFF) begin
            regWrData <= d & 8'hbf;
        end else begin
            regWrData <= d;
        end
        @(posedge sys_clk);
        regWrite <= 1'b0;
        regWrData <= ~d;
    endtask

    // Two writes to one address on consecutive cycles, strobe held high
    task automatic wr_pair(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d0;
        @(posedge sys_clk);
        regWrData <= d1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        regWrData <= ~d1;
    endtask

    // Write then read of one data register with no idle cycle between
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        regWrData <= ~d;
        #1;
        q = regRdData;
    endtask

    // One-cycle read, data taken in the following cycle only
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        d = regRdData;
    endtask
endmodule

// [testbench/hdca_top_tb.sv]
// Purpose: Self-checking bench for the HDLC channel routing
// Assumes: same framer position fed to both directions
// Notes:   Routing outputs are sampled 1 ns after inputs change
`timescale 1ns/1ps
module hdca_top_tb
    import hdca_pkg::*;
;
    // -----------------------------------------------
    // Signals
    // -----------------------------------------------
    logic       sys_clk;        // 10 MHz clock
    logic       reset;          // Sync reset
    logic [7:0] regAddr;        // Host bus
    logic [7:0] regWrData;
    logic       regWrite;
    logic       regRead;
    logic [7:0] regRdData;
    logic [4:0] slotNum;        // Framer slot
    logic [2:0] bitNum;         // Framer bit
    logic       blkSel;         // Block select, both directions
    logic       rxFdl;
    logic       rxEn;
    logic       txFdl;
    logic       txEn;
    logic [7:0] txByte;
    logic       byteValid;
    logic [7:0] rd;             // Read result
    int         miscompares;
    int         samplesChecked;

    hdca_top u_hdca_top (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .rxSlotNum(slotNum), .rxBitNum(bitNum),
        .rxChannelBlockSelect(blkSel), .txSlotNum(slotNum), .txBitNum(bitNum),
        .txChannelBlockSelect(blkSel), .rxUseFacilityDataLink(rxFdl),
        .rxHdlcBitEnable(rxEn), .txUseFacilityDataLink(txFdl),
        .txHdlcBitEnable(txEn), .txHdlcByte(txByte), .txHdlcByteValid(byteValid));

    hdca_host_model u_hdca_host_model (.sys_clk(sys_clk), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData));

    // Clock generator
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // -----------------------------------------------
    // Helpers
    // -----------------------------------------------
    // Wide enough for a valid flag packed beside a byte
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // Position change just after an edge, then settle
    task automatic pos(input logic [4:0] s, input logic [2:0] b, input logic bs);
        @(posedge sys_clk);
        slotNum <= s;
        bitNum <= b;
        blkSel <= bs;
        #1;
    endtask

    task automatic stop_test;
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // -----------------------------------------------
    // Scenarios
    // -----------------------------------------------
    // Reset contents, byte port and unmapped reads as zero
    task automatic t_reset;
        logic [7:0] offs [5] = '{8'h90, 8'h91, 8'h92, 8'h08, 8'h55};
        foreach (offs[i]) begin
            u_hdca_host_model.rd(offs[i], rd);
            chk(rd, 8'h00);
        end
        chk(rxFdl, 1'b1);
        chk(txFdl, 1'b1);
    endtask

    // Back-to-back packet bytes, full byte kept in order
    task automatic t_bytes;
        u_hdca_host_model.wr(HDCA_TX_FIFO_OFF, 8'h81);
        #1;
        chk({byteValid, txByte}, 9'h181);
        u_hdca_host_model.wr(HDCA_TX_FIFO_OFF, 8'h7e);
        #1;
        chk({byteValid, txByte}, 9'h17e);
        @(posedge sys_clk);
        #1;
        chk({byteValid, txByte}, 9'h07e);
        // Truly back to back: one pulse per byte, no gap between
        fork
            u_hdca_host_model.wr_pair(HDCA_TX_FIFO_OFF, 8'h01, 8'h80);
            begin
                repeat (2) @(posedge sys_clk);
                #1;
                chk({byteValid, txByte}, 9'h101);
                @(posedge sys_clk);
                #1;
                chk({byteValid, txByte}, 9'h180);
                @(posedge sys_clk);
                #1;
                chk({byteValid, txByte}, 9'h080);
            end
        join
    endtask

    // Highest slot number with DS0 bits 8 and 1 suppressed
    task automatic t_single;
        u_hdca_host_model.wr(HDCA_RX_CTRL_OFF, 8'h97);
        u_hdca_host_model.wr_rd(HDCA_RX_SUPP_OFF, 8'h81, rd);
        chk(rd, 8'h81);
        u_hdca_host_model.rd(HDCA_RX_CTRL_OFF, rd);
        chk(rd, 8'h97);
        for (int s = 22; s < 25; s++) begin
            for (int b = 0; b < 8; b++) begin
                pos(5'(s), 3'(b), 1'b1);
                chk(rxFdl, 1'b0);
                chk(rxEn, s == 23 && b != 0 && b != 7);
            end
        end
    endtask

    // Block select overrides the channel number, then back to data link
    task automatic t_block;
        u_hdca_host_model.wr(HDCA_TX_CTRL_OFF, 8'he3);
        u_hdca_host_model.rd(HDCA_TX_CTRL_OFF, rd);
        chk(rd, 8'ha3);
        u_hdca_host_model.wr(HDCA_RX_CTRL_OFF, 8'ha0);
        pos(5'h03, 3'h3, 1'b0);
        chk({txFdl, txEn, rxEn}, 3'b000);
        pos(5'h03, 3'h3, 1'b1);
        chk({txFdl, txEn, rxEn}, 3'b011);
        pos(5'h03, 3'h0, 1'b1);
        chk({txFdl, txEn, rxEn}, 3'b010);
        u_hdca_host_model.wr(HDCA_TX_CTRL_OFF, 8'h23);
        #1;
        chk({txFdl, txEn}, 2'b10);
    endtask

    // -----------------------------------------------
    // Main sequence and watchdog
    // -----------------------------------------------
    initial begin
        reset = 1'b1;
        slotNum = 5'h00;
        bitNum = 3'h0;
        blkSel = 1'b0;
        miscompares = 0;
        samplesChecked = 0;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_bytes();
        t_single();
        t_block();
        stop_test();
    end

    // Cuts a hang short at 10000 cycles, far above the test's length
    initial begin
        #1000000;
        miscompares++;
        stop_test();
    end
endmodule
